/* rtl/rbt_pkg.sv */
// Shared constants, mode type and control decode for the registered transceiver.
// Assumes one system clock; every pin input is synchronous to that clock.
package rbt_pkg;

   // ----------------------------------------------------------------
   // Widths and depths
   // ----------------------------------------------------------------
   localparam int RBT_DATA_W = 8;
   localparam int RBT_FIFO_DEPTH = 32;
   localparam int RBT_COUNT_W = 16;
   localparam int RBT_LOG_W = 2 * RBT_DATA_W + 2;

   // ----------------------------------------------------------------
   // Capture log record layout
   // ----------------------------------------------------------------
   localparam int RBT_LOG_A_LSB = 0;
   localparam int RBT_LOG_B_LSB = RBT_DATA_W;
   localparam int RBT_LOG_A_FLAG = 2 * RBT_DATA_W;
   localparam int RBT_LOG_B_FLAG = 2 * RBT_DATA_W + 1;

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam logic [RBT_DATA_W-1:0] RBT_STORE_RESET = 8'h00;
   localparam logic [RBT_DATA_W-1:0] RBT_OUT_RESET = 8'h00;
   localparam logic [RBT_COUNT_W-1:0] RBT_COUNT_RESET = 16'h0000;
   localparam logic RBT_CAP_PREV_RESET = 1'b1;

   // ----------------------------------------------------------------
   // Transfer modes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      RBT_ISOLATE,
      RBT_B_LIVE_TO_A,
      RBT_B_STORED_TO_A,
      RBT_A_LIVE_TO_B,
      RBT_A_STORED_TO_B
   } rbt_mode_t;

   // Selects of the idle direction never reach the result
   function automatic rbt_mode_t rbt_decode_mode(
      input logic oe_n,
      input logic dir,
      input logic sel_ab,
      input logic sel_ba
   );
      rbt_mode_t m;
      m = RBT_ISOLATE;
      if (oe_n) begin
         m = RBT_ISOLATE;
      end else if (!dir) begin
         m = sel_ba ? RBT_B_STORED_TO_A : RBT_B_LIVE_TO_A;
      end else begin
         m = sel_ab ? RBT_A_STORED_TO_B : RBT_A_LIVE_TO_B;
      end
      return m;
   endfunction : rbt_decode_mode

endpackage : rbt_pkg

/* rtl/rbt_stream_if.sv */
// Valid/ready word stream between the transceiver core and its log buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rbt_stream_if #(
   parameter int WIDTH = rbt_pkg::RBT_LOG_W
);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;

   // Producer drives valid and data
   modport src (
      output valid,
      output data,
      input ready
   );

   // Consumer drives ready
   modport snk (
      input valid,
      input data,
      output ready
   );
endinterface : rbt_stream_if

/* rtl/rbt_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module rbt_fifo #(
   parameter int WIDTH = rbt_pkg::RBT_LOG_W,
   parameter int DEPTH = rbt_pkg::RBT_FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic reset,
   rbt_stream_if.snk in_if,
   rbt_stream_if.src out_if
);
   import rbt_pkg::*;

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   wire logic full;
   wire logic empty;
   wire logic do_push;
   wire logic do_pop;

   // ----------------------------------------------------------------
   // Status
   // ----------------------------------------------------------------
   // Extra pointer bit tells full from empty without a counter
   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                 (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign in_if.ready = !full;
   assign out_if.valid = !empty;
   assign out_if.data = mem[rd_ptr_reg[AW-1:0]];
   assign do_push = in_if.valid && !full;
   assign do_pop = out_if.ready && !empty;

   // ----------------------------------------------------------------
   // Storage and pointers
   // ----------------------------------------------------------------
   // Storage array carries no reset; only pointers need defined state
   always_ff @(posedge mclk) begin
      if (do_push) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_if.data;
      end
   end

   // Pointer update
   always_ff @(posedge mclk) begin
      if (reset) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (do_push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (do_pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end

endmodule : rbt_fifo

/* rtl/rbt_capture.sv */
// One capture register: rising-edge detect on a capture clock pin, then store.
// Assumes the capture clock pin is synchronous to mclk and held at least one cycle.
`timescale 1ns/1ps
module rbt_capture #(
   parameter int WIDTH = rbt_pkg::RBT_DATA_W
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic capture_clock,
   input wire logic [WIDTH-1:0] pins,
   output logic [WIDTH-1:0] stored,
   output logic captured
);
   import rbt_pkg::*;

   logic prev_reg;
   logic [WIDTH-1:0] store_reg;
   logic captured_reg;
   wire logic cap_edge;

   // Low-to-high seen between two samples; no enable term on purpose
   assign cap_edge = capture_clock && !prev_reg;
   assign stored = store_reg;
   assign captured = captured_reg;

   // Previous level; reset high so a pin already high is not an edge
   always_ff @(posedge mclk) begin
      if (reset) begin
         prev_reg <= RBT_CAP_PREV_RESET;
         captured_reg <= 1'b0;
      end else begin
         prev_reg <= capture_clock;
         captured_reg <= cap_edge;
      end
   end

   // Data store; reset value is only for tidy simulation, not a promise
   always_ff @(posedge mclk) begin
      if (reset) begin
         store_reg <= RBT_STORE_RESET;
      end else if (cap_edge) begin
         store_reg <= pins;
      end
   end

endmodule : rbt_capture

/* rtl/rbt_top.sv */
// Top of the registered 8-bit bus transceiver with capture log.
// Assumes all pins are synchronous to mclk and the wire level of each port
// is resolved outside from the output enables.
//
// Overview of operation
// - Two 8-bit registers, one per port.
// - A register feeds B; B register feeds A.
// - Each register loads on its clock's rise.
// - Capture is never gated by any control.
// - Enable high isolates both ports; capture continues.
// - Direction low drives A, high drives B.
// - Live B data onto A when selected.
// - Stored B register onto A when selected.
// - Live A data onto B when selected.
// - Stored A register onto B when selected.
// - Never drive both ports at once.
// - Receiving port may load either or both.
// - Don't-care controls have no effect.
`timescale 1ns/1ps
module rbt_top #(
   parameter int FIFO_DEPTH = rbt_pkg::RBT_FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic output_enable_n,
   input wire logic direction,
   input wire logic a_to_b_source_select,
   input wire logic b_to_a_source_select,
   input wire logic a_to_b_capture_clock,
   input wire logic b_to_a_capture_clock,
   input wire logic [rbt_pkg::RBT_DATA_W-1:0] port_a_in,
   output logic [rbt_pkg::RBT_DATA_W-1:0] port_a_out,
   output logic port_a_oe,
   input wire logic [rbt_pkg::RBT_DATA_W-1:0] port_b_in,
   output logic [rbt_pkg::RBT_DATA_W-1:0] port_b_out,
   output logic port_b_oe,
   output rbt_pkg::rbt_mode_t mode_status,
   output logic [rbt_pkg::RBT_DATA_W-1:0] a_to_b_stored_status,
   output logic [rbt_pkg::RBT_DATA_W-1:0] b_to_a_stored_status,
   output logic [rbt_pkg::RBT_COUNT_W-1:0] a_to_b_capture_count,
   output logic [rbt_pkg::RBT_COUNT_W-1:0] b_to_a_capture_count,
   output logic [rbt_pkg::RBT_LOG_W-1:0] log_data,
   output logic log_valid,
   input wire logic log_ready,
   output logic log_space,
   output logic log_overrun,
   input wire logic log_overrun_clear
);
   import rbt_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   // Index 0 is the register loaded from port A, index 1 from port B
   wire logic [1:0] cap_clk;
   wire logic [1:0][RBT_DATA_W-1:0] cap_pins;
   wire logic [1:0][RBT_DATA_W-1:0] stored;
   wire logic [1:0] captured;

   wire rbt_mode_t mode_next;
   wire logic a_drive_next;
   wire logic b_drive_next;
   wire logic [RBT_DATA_W-1:0] a_data_next;
   wire logic [RBT_DATA_W-1:0] b_data_next;
   wire logic [RBT_DATA_W-1:0] a_source;
   wire logic [RBT_DATA_W-1:0] b_source;

   wire logic push_valid;
   wire logic [RBT_LOG_W-1:0] push_record;
   wire logic push_lost;
   wire logic overrun_next;
   wire logic pop_take;
   wire logic [RBT_COUNT_W-1:0] count_a_next;
   wire logic [RBT_COUNT_W-1:0] count_b_next;

   rbt_mode_t mode_reg;
   logic port_a_oe_reg;
   logic port_b_oe_reg;
   logic [RBT_DATA_W-1:0] port_a_out_reg;
   logic [RBT_DATA_W-1:0] port_b_out_reg;
   logic [RBT_DATA_W-1:0] stored_a_reg;
   logic [RBT_DATA_W-1:0] stored_b_reg;
   logic [RBT_COUNT_W-1:0] count_a_reg;
   logic [RBT_COUNT_W-1:0] count_b_reg;
   logic [RBT_LOG_W-1:0] log_data_reg;
   logic log_valid_reg;
   logic log_space_reg;
   logic log_overrun_reg;

   rbt_stream_if #(.WIDTH(RBT_LOG_W)) push_if ();
   rbt_stream_if #(.WIDTH(RBT_LOG_W)) pop_if ();

   // ----------------------------------------------------------------
   // Capture registers
   // ----------------------------------------------------------------
   // Each register samples its own port pins; the pin level is the
   // resolved wire, so a port we drive captures our own output.
   assign cap_clk[0] = a_to_b_capture_clock;
   assign cap_clk[1] = b_to_a_capture_clock;
   assign cap_pins[0] = port_a_in;
   assign cap_pins[1] = port_b_in;

   // No mode, enable or select term reaches the capture path
   generate
      for (genvar g = 0; g < 2; g++) begin : g_cap
         rbt_capture #(
            .WIDTH(RBT_DATA_W)
         ) u_cap (
            .mclk(mclk),
            .reset(reset),
            .capture_clock(cap_clk[g]),
            .pins(cap_pins[g]),
            .stored(stored[g]),
            .captured(captured[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Control decode
   // ----------------------------------------------------------------
   // Isolation overrides everything; idle selects are ignored
   assign mode_next = rbt_decode_mode(output_enable_n, direction,
                                      a_to_b_source_select,
                                      b_to_a_source_select);

   // Exactly one mode per cycle, so at most one side can be enabled
   assign a_drive_next = (mode_next == RBT_B_LIVE_TO_A) ||
                         (mode_next == RBT_B_STORED_TO_A);
   assign b_drive_next = (mode_next == RBT_A_LIVE_TO_B) ||
                         (mode_next == RBT_A_STORED_TO_B);

   // ----------------------------------------------------------------
   // Output data selection
   // ----------------------------------------------------------------
   // Register from B heads for A and the one from A heads for B
   assign a_source = (mode_next == RBT_B_STORED_TO_A) ? stored[1]
                                                      : port_b_in;
   assign b_source = (mode_next == RBT_A_STORED_TO_B) ? stored[0]
                                                      : port_a_in;

   // Undriven side parks at zero so a stale value never reappears
   assign a_data_next = a_drive_next ? a_source : RBT_OUT_RESET;
   assign b_data_next = b_drive_next ? b_source : RBT_OUT_RESET;

   // ----------------------------------------------------------------
   // Port drivers
   // ----------------------------------------------------------------
   // One cycle of latency buys flop-driven pins; the enables move on
   // the same edge, so a turnaround never overlaps the two drivers.
   always_ff @(posedge mclk) begin
      if (reset) begin
         port_a_oe_reg <= 1'b0;
         port_b_oe_reg <= 1'b0;
      end else begin
         port_a_oe_reg <= a_drive_next;
         port_b_oe_reg <= b_drive_next;
      end
   end

   // Port data values
   always_ff @(posedge mclk) begin
      if (reset) begin
         port_a_out_reg <= RBT_OUT_RESET;
         port_b_out_reg <= RBT_OUT_RESET;
      end else begin
         port_a_out_reg <= a_data_next;
         port_b_out_reg <= b_data_next;
      end
   end

   // Mode readback
   always_ff @(posedge mclk) begin
      if (reset) begin
         mode_reg <= RBT_ISOLATE;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // ----------------------------------------------------------------
   // Stored value readback
   // ----------------------------------------------------------------
   // Mirrors lag the capture registers by one cycle
   always_ff @(posedge mclk) begin
      if (reset) begin
         stored_a_reg <= RBT_STORE_RESET;
         stored_b_reg <= RBT_STORE_RESET;
      end else begin
         stored_a_reg <= stored[0];
         stored_b_reg <= stored[1];
      end
   end

   // ----------------------------------------------------------------
   // Capture counters
   // ----------------------------------------------------------------
   // Free-running, wrap silently; software takes differences
   assign count_a_next = count_a_reg + 1'b1;
   assign count_b_next = count_b_reg + 1'b1;

   // One count per capture edge
   always_ff @(posedge mclk) begin
      if (reset) begin
         count_a_reg <= RBT_COUNT_RESET;
         count_b_reg <= RBT_COUNT_RESET;
      end else begin
         if (captured[0]) count_a_reg <= count_a_next;
         if (captured[1]) count_b_reg <= count_b_next;
      end
   end

   // ----------------------------------------------------------------
   // Capture log
   // ----------------------------------------------------------------
   // One record per cycle with any capture; both edges in the same cycle
   // share a record, so neither is dropped by a single write port.
   assign push_valid = |captured;
   assign push_record[RBT_LOG_A_LSB +: RBT_DATA_W] = stored[0];
   assign push_record[RBT_LOG_B_LSB +: RBT_DATA_W] = stored[1];
   assign push_record[RBT_LOG_A_FLAG] = captured[0];
   assign push_record[RBT_LOG_B_FLAG] = captured[1];
   assign push_if.valid = push_valid;
   assign push_if.data = push_record;

   // A full buffer loses log records but never holds off a capture
   assign push_lost = push_valid && !push_if.ready;

   // Log buffer
   rbt_fifo #(
      .WIDTH(RBT_LOG_W),
      .DEPTH(FIFO_DEPTH)
   ) u_log_fifo (
      .mclk(mclk),
      .reset(reset),
      .in_if(push_if),
      .out_if(pop_if)
   );

   // Sticky overrun; a loss in the clearing cycle still sets it
   assign overrun_next = push_lost ? 1'b1
                       : (log_overrun_clear ? 1'b0 : log_overrun_reg);

   // Overrun flag and space indication
   always_ff @(posedge mclk) begin
      if (reset) begin
         log_overrun_reg <= 1'b0;
         log_space_reg <= 1'b0;
      end else begin
         log_overrun_reg <= overrun_next;
         log_space_reg <= push_if.ready;
      end
   end

   // ----------------------------------------------------------------
   // Log output stage
   // ----------------------------------------------------------------
   // Holding register keeps the user-side outputs on flops; a stalled
   // reader lets the buffer fill, which is what drives the overrun.
   assign pop_take = !log_valid_reg || log_ready;
   assign pop_if.ready = pop_take;

   // Output word and valid
   always_ff @(posedge mclk) begin
      if (reset) begin
         log_valid_reg <= 1'b0;
         log_data_reg <= '0;
      end else if (pop_take) begin
         log_valid_reg <= pop_if.valid;
         if (pop_if.valid) log_data_reg <= pop_if.data;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign port_a_out = port_a_out_reg;
   assign port_a_oe = port_a_oe_reg;
   assign port_b_out = port_b_out_reg;
   assign port_b_oe = port_b_oe_reg;
   assign mode_status = mode_reg;
   assign a_to_b_stored_status = stored_a_reg;
   assign b_to_a_stored_status = stored_b_reg;
   assign a_to_b_capture_count = count_a_reg;
   assign b_to_a_capture_count = count_b_reg;
   assign log_data = log_data_reg;
   assign log_valid = log_valid_reg;
   assign log_space = log_space_reg;
   assign log_overrun = log_overrun_reg;

endmodule : rbt_top

/* bench/rbt_monitor.sv */
// Checker for the transceiver top: port drive, capture and log stream relations.
// Assumes it is bound to rbt_top and sees only that module's ports.
`timescale 1ns/1ps
module rbt_monitor (
   input wire logic mclk,
   input wire logic reset,
   input wire logic output_enable_n,
   input wire logic direction,
   input wire logic a_to_b_source_select,
   input wire logic b_to_a_source_select,
   input wire logic a_to_b_capture_clock,
   input wire logic b_to_a_capture_clock,
   input wire logic [rbt_pkg::RBT_DATA_W-1:0] port_a_in,
   input wire logic [rbt_pkg::RBT_DATA_W-1:0] port_a_out,
   input wire logic port_a_oe,
   input wire logic [rbt_pkg::RBT_DATA_W-1:0] port_b_in,
   input wire logic [rbt_pkg::RBT_DATA_W-1:0] port_b_out,
   input wire logic port_b_oe,
   input wire rbt_pkg::rbt_mode_t mode_status,
   input wire logic [rbt_pkg::RBT_DATA_W-1:0] a_to_b_stored_status,
   input wire logic [rbt_pkg::RBT_DATA_W-1:0] b_to_a_stored_status,
   input wire logic [rbt_pkg::RBT_COUNT_W-1:0] a_to_b_capture_count,
   input wire logic [rbt_pkg::RBT_COUNT_W-1:0] b_to_a_capture_count,
   input wire logic [rbt_pkg::RBT_LOG_W-1:0] log_data,
   input wire logic log_valid,
   input wire logic log_ready,
   input wire logic log_space,
   input wire logic log_overrun,
   input wire logic log_overrun_clear
);
   import rbt_pkg::*;

   // ------------------------------------------------------------
   // Port drive
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   one_driver_a: assert property (!(port_a_oe && port_b_oe))
      else $error("both ports driven at once");
   isolate_a: assert property (output_enable_n |=> !port_a_oe && !port_b_oe
      && mode_status == RBT_ISOLATE) else $error("port driven during isolation");
   dir_pick_a: assert property (!output_enable_n |=> port_a_oe != $past(direction)
      && port_b_oe == $past(direction)) else $error("wrong port driven for direction");
   live_ba_a: assert property (!output_enable_n && !direction && !b_to_a_source_select
      |=> port_a_out == $past(port_b_in)) else $error("live b data not on port a");
   live_ab_a: assert property (!output_enable_n && direction && !a_to_b_source_select
      |=> port_b_out == $past(port_a_in)) else $error("live a data not on port b");
   // Stored output and status mirror show the same register in the same cycle
   stored_ba_a: assert property (!output_enable_n && !direction && b_to_a_source_select
      |=> port_a_out == b_to_a_stored_status) else $error("stored b data not on port a");
   stored_ab_a: assert property (!output_enable_n && direction && a_to_b_source_select
      |=> port_b_out == a_to_b_stored_status) else $error("stored a data not on port b");

   // ------------------------------------------------------------
   // Capture and log
   // ------------------------------------------------------------
   // A clock already high at release is not an edge, hence the reset term
   cap_ab_a: assert property ($rose(a_to_b_capture_clock) && !$past(reset)
      |-> ##2 a_to_b_stored_status == $past(port_a_in, 2)) else $error("a capture lost");
   cap_ba_a: assert property ($rose(b_to_a_capture_clock) && !$past(reset)
      |-> ##2 b_to_a_stored_status == $past(port_b_in, 2)
      && b_to_a_capture_count == 16'($past(b_to_a_capture_count, 2) + 1))
      else $error("b capture lost or not counted");
   overrun_hold_a: assert property (log_overrun && !log_overrun_clear |=> log_overrun)
      else $error("overrun flag dropped");
   log_hold_a: assert property (log_valid && !log_ready |=> log_valid && $stable(log_data))
      else $error("log word changed before taken");
endmodule : rbt_monitor

bind rbt_top rbt_monitor mon_u (
   .mclk, .reset, .output_enable_n, .direction, .a_to_b_source_select,
   .b_to_a_source_select, .a_to_b_capture_clock, .b_to_a_capture_clock,
   .port_a_in, .port_a_out, .port_a_oe, .port_b_in, .port_b_out, .port_b_oe,
   .mode_status, .a_to_b_stored_status, .b_to_a_stored_status,
   .a_to_b_capture_count, .b_to_a_capture_count, .log_data, .log_valid,
   .log_ready, .log_space, .log_overrun, .log_overrun_clear
);

/* bench/rbt_bus_model.sv */
// Bus logic on both ports of the transceiver; resolves each port's wire level.
// Assumes the bench gives the value this logic wants to place on each port.
`timescale 1ns/1ps
module rbt_bus_model (
   input wire logic [rbt_pkg::RBT_DATA_W-1:0] a_want,
   input wire logic [rbt_pkg::RBT_DATA_W-1:0] b_want,
   input wire logic [rbt_pkg::RBT_DATA_W-1:0] port_a_out,
   input wire logic port_a_oe,
   input wire logic [rbt_pkg::RBT_DATA_W-1:0] port_b_out,
   input wire logic port_b_oe,
   output logic [rbt_pkg::RBT_DATA_W-1:0] port_a_in,
   output logic [rbt_pkg::RBT_DATA_W-1:0] port_b_in
);
   import rbt_pkg::*;

   // Step off a port as soon as the transceiver claims it, so no contention
   assign port_a_in = port_a_oe ? port_a_out : a_want;
   assign port_b_in = port_b_oe ? port_b_out : b_want;
endmodule : rbt_bus_model

/* bench/rbt_top_tb.sv */
// Self-checking bench for the transceiver: mode table, captures, log buffer.
// Assumes a shallow log buffer so that overrun is reached in a few captures.
`timescale 1ns/1ps
module rbt_top_tb;
   import rbt_pkg::*;
   typedef struct packed {
      logic [3:0] ctl;
      logic [1:0] oe;
      logic [2:0] mode;
      logic [7:0] aout;
      logic [7:0] bout;
   } rbt_row_t;
   localparam int DEPTH = 4;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] ctl = 4'b1000;
   logic cab = 1'b0;
   logic cba = 1'b0;
   logic [7:0] a_want = 8'h00;
   logic [7:0] b_want = 8'h00;
   logic lready = 1'b1;
   logic lclr = 1'b0;
   logic [7:0] pa_in, pa_out, pb_in, pb_out, sa, sb;
   logic pa_oe, pb_oe, lvalid, lspace, lover;
   logic [15:0] ca, cb;
   logic [17:0] ldata;
   rbt_mode_t mode;
   int n_errors = 0;
   int checks_done = 0;
   int k, words;
   // Controls {enable_n, direction, a-select, b-select}, oe {a, b}, mode, a out, b out
   rbt_row_t rows [10] = '{
      {4'b1011, 2'b00, RBT_ISOLATE, 8'h00, 8'h00},
      {4'b1100, 2'b00, RBT_ISOLATE, 8'h00, 8'h00},
      {4'b0000, 2'b10, RBT_B_LIVE_TO_A, 8'h69, 8'h00},
      {4'b0010, 2'b10, RBT_B_LIVE_TO_A, 8'h69, 8'h00},
      {4'b0001, 2'b10, RBT_B_STORED_TO_A, 8'h3C, 8'h00},
      {4'b0011, 2'b10, RBT_B_STORED_TO_A, 8'h3C, 8'h00},
      {4'b0100, 2'b01, RBT_A_LIVE_TO_B, 8'h00, 8'h96},
      {4'b0101, 2'b01, RBT_A_LIVE_TO_B, 8'h00, 8'h96},
      {4'b0110, 2'b01, RBT_A_STORED_TO_B, 8'h00, 8'hC3},
      {4'b0111, 2'b01, RBT_A_STORED_TO_B, 8'h00, 8'hC3}};

   // Clock: 4 ns period
   always #2 mclk = ~mclk;

   rbt_top #(.FIFO_DEPTH(DEPTH)) dut_u (
      .mclk(mclk), .reset(reset), .output_enable_n(ctl[3]), .direction(ctl[2]),
      .a_to_b_source_select(ctl[1]), .b_to_a_source_select(ctl[0]),
      .a_to_b_capture_clock(cab), .b_to_a_capture_clock(cba),
      .port_a_in(pa_in), .port_a_out(pa_out), .port_a_oe(pa_oe),
      .port_b_in(pb_in), .port_b_out(pb_out), .port_b_oe(pb_oe), .mode_status(mode),
      .a_to_b_stored_status(sa), .b_to_a_stored_status(sb),
      .a_to_b_capture_count(ca), .b_to_a_capture_count(cb), .log_data(ldata),
      .log_valid(lvalid), .log_ready(lready), .log_space(lspace),
      .log_overrun(lover), .log_overrun_clear(lclr));

   rbt_bus_model model_u (
      .a_want(a_want), .b_want(b_want), .port_a_out(pa_out), .port_a_oe(pa_oe),
      .port_b_out(pb_out), .port_b_oe(pb_oe), .port_a_in(pa_in), .port_b_in(pb_in));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc

   task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Low, high, low: each capture clock stays a full cycle at each level
   task automatic cap(input logic ta, input logic tb, input logic [7:0] av,
                      input logic [7:0] bv);
      cab = 1'b0;
      cba = 1'b0;
      cyc(1);
      cab = ta;
      cba = tb;
      a_want = av;
      b_want = bv;
      cyc(1);
      cab = 1'b0;
      cba = 1'b0;
      cyc(1);
   endtask : cap

   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      cyc(3);
      reset = 1'b0;
      cyc(1);
      chk("reset state", 18'h0_0000, 18'({pa_oe, pb_oe, mode, lvalid, lover}));
      chk("reset counts", 18'h0_0000, 18'(ca | cb));
      // Both registers loaded on one edge while isolated
      cap(1'b1, 1'b1, 8'hC3, 8'h3C);
      chk("a store", 18'(8'hC3), 18'(sa));
      chk("b store", 18'(8'h3C), 18'(sb));
      chk("counts", 18'(16'h0101), 18'({ca[7:0], cb[7:0]}));
      a_want = 8'h96;
      b_want = 8'h69;
      // Two cycles per row: the port just released must settle before live data is read
      foreach (rows[i]) begin
         ctl = rows[i].ctl;
         cyc(2);
         chk("oe", 18'(rows[i].oe), 18'({pa_oe, pb_oe}));
         chk("mode", 18'(rows[i].mode), 18'(mode));
         chk("a out", 18'(rows[i].aout), 18'(pa_out));
         chk("b out", 18'(rows[i].bout), 18'(pb_out));
      end
      // Capture the receiving port while port a is driven with stored b data
      ctl = 4'b0001;
      cap(1'b0, 1'b1, 8'h96, 8'hE7);
      chk("b store live", 18'(8'hE7), 18'(sb));
      chk("stored to a", 18'(8'hE7), 18'(pa_out));
      // That capture's record must leave the buffer before the reader stalls
      ctl = 4'b1000;
      cyc(1);
      chk("log b word", {2'b10, 8'hE7, 8'hC3}, ldata);
      cyc(1);
      // Fill the log with the reader stalled; one record more than it can hold
      lready = 1'b0;
      for (k = 0; k <= DEPTH + 1; k++) begin
         cap(1'b1, 1'b0, 8'(8'h10 + k), 8'hE7);
      end
      cyc(2);
      chk("overrun", 18'(1'b1), 18'(lover));
      chk("space", 18'(1'b0), 18'(lspace));
      lclr = 1'b1;
      cyc(1);
      lclr = 1'b0;
      cyc(1);
      chk("overrun clear", 18'(1'b0), 18'(lover));
      // Drain: words come out in capture order, the dropped one never appears
      lready = 1'b1;
      words = 0;
      for (k = 0; k < 10; k++) begin
         if (lvalid === 1'b1) begin
            chk("log word", {2'b01, 8'hE7, 8'(8'h10 + words)}, ldata);
            words++;
         end
         cyc(1);
      end
      chk("log count", 18'(DEPTH + 1), 18'(words));
      // Reset in mid-run while port a is driven: drivers, mode and the a count drop
      ctl = 4'b0001;
      cyc(2);
      reset = 1'b1;
      cyc(1);
      chk("mid reset", 18'h0_0000, 18'({pa_oe, pb_oe, mode, ca[7:0]}));
      reset = 1'b0;
      cyc(1);
      chk("after reset", 18'h0_0012, 18'({pa_oe, pb_oe, mode}));
      summarize();
   end
endmodule : rbt_top_tb
